/* src/rsq_pkg.sv */
// Package for the reset sequencer and interrupt enable block.
// Assumes a single 250 MHz clock and an AHB-Lite register bus.
package rsq_pkg;
  localparam logic [11:0] RSQ_OFS_IRQ_EN   = 12'h008;
  localparam logic [11:0] RSQ_OFS_TEST     = 12'h00C;
  localparam logic [11:0] RSQ_OFS_XTAL     = 12'h010;
  localparam logic [11:0] RSQ_OFS_XTAL2    = 12'h014;
  localparam logic [11:0] RSQ_OFS_WDOG     = 12'h018;
  localparam logic [11:0] RSQ_OFS_STATUS   = 12'h01C;
  localparam int          RSQ_BIT_TICK_EN  = 7;
  localparam int          RSQ_BIT_LOCK_EN  = 4;
  localparam int          RSQ_BIT_CORR_EN  = 1;
  localparam int          RSQ_BIT_XTAL_EN  = 7;
  localparam int          RSQ_BIT_MON_EN   = 0;
  localparam logic [7:0]  RSQ_IRQ_EN_RST   = 8'h00;
  localparam logic [7:0]  RSQ_TEST_RST     = 8'h00;
  localparam logic [7:0]  RSQ_XTAL_RST     = 8'h00;
  localparam logic [7:0]  RSQ_XTAL2_RST    = 8'h00;
  localparam logic [7:0]  RSQ_WDOG_RST     = 8'h00;
  localparam logic [9:0]  RSQ_PIN_CYCLES   = 10'd512;
  localparam logic [9:0]  RSQ_SEQ_CYCLES   = 10'd768;
  localparam logic [1:0]  RSQ_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {RSQ_IDLE, RSQ_PIN, RSQ_TAIL, RSQ_EXT} rsq_state_e;
endpackage : rsq_pkg

/* src/rsq_seq.sv */
// Reset sequence generator: drives the reset pin and holds the internal reset.
// Assumes the pin level is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module rsq_seq
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic src_event,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      sys_reset,
  output logic      busy
);
  import rsq_pkg::*;

  rsq_state_e state_r;
  rsq_state_e state_nxt;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;

  wire cnt_last = (cnt_r == RSQ_SEQ_CYCLES - 10'd1);
  wire pin_done = (cnt_r == RSQ_PIN_CYCLES - 10'd1);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 10'd1;
    unique case (state_r)
      RSQ_IDLE:
      begin
        cnt_nxt = 10'd0;
        if (src_event || !pin_in)
          state_nxt = src_event ? RSQ_PIN : RSQ_EXT;
      end
      RSQ_PIN:
        if (pin_done)
          state_nxt = RSQ_TAIL;
      RSQ_TAIL:
        if (cnt_last)
        begin
          cnt_nxt   = 10'd0;
          state_nxt = pin_in ? RSQ_IDLE : RSQ_EXT;
        end
      RSQ_EXT:
      begin
        cnt_nxt = 10'd0;
        if (pin_in)
          state_nxt = RSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= RSQ_PIN;
      cnt_r   <= 10'd0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign pin_out   = 1'b0;
  assign pin_oe    = (state_r == RSQ_PIN);
  assign sys_reset = (state_r != RSQ_IDLE);
  assign busy      = sys_reset;

  a_pin_len: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(pin_oe) |-> pin_oe [*8]) else $error("pin drive too short");
  a_pin_release: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(pin_oe) |-> sys_reset) else $error("reset dropped with pin");
  a_ext_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == RSQ_EXT && !pin_in) |=> sys_reset) else $error("ext reset lost");
  a_count_pin: assert property (@(posedge core_clk) disable iff (!resetn)
    pin_oe |-> cnt_r < RSQ_PIN_CYCLES) else $error("pin count overran");
  c_ext: cover property (@(posedge core_clk) disable iff (!resetn) state_r == RSQ_EXT);
endmodule : rsq_seq
`default_nettype wire

/* src/rsq_top.sv */
// Interrupt enables, reset source gating and reset sequencing behind AHB-Lite.
// Assumes one clock; flags and mode inputs are synchronous to core_clk.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rsq_top
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        tick_flag,
  input  wire logic        pll_locked_change_flag,
  input  wire logic        clock_corrupt_flag,
  input  wire logic        special_mode,
  input  wire logic        full_stop_mode,
  input  wire logic        osc_lost,
  input  wire logic        osc_below_threshold,
  input  wire logic        watchdog_timeout,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             sys_reset,
  output logic             vco_reset_select,
  output logic             crystal_run,
  output logic             tick_irq,
  output logic             pll_locked_irq,
  output logic             clock_corrupt_irq,
  output logic             watchdog_armed
);
  import rsq_pkg::*;

  logic [7:0]  irq_en_r;
  logic [7:0]  test_r;
  logic [7:0]  xtal_r;
  logic [7:0]  xtal2_r;
  logic [7:0]  wdog_r;
  logic        dp_wr_r;
  logic [11:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic        mon_rst_r;
  logic        wd_rst_r;

  // Address phase decode and data phase write decode.
  wire         ap_valid  = hsel && hready && htrans[1];
  wire         ap_read   = ap_valid && !hwrite;
  wire [11:0]  ap_addr   = haddr[11:0];
  wire [11:0]  dp_addr   = dp_addr_r;
  wire         wr_irq    = dp_wr_r && (dp_addr == RSQ_OFS_IRQ_EN);
  wire         wr_test   = dp_wr_r && (dp_addr == RSQ_OFS_TEST) && special_mode;
  wire         wr_xtal   = dp_wr_r && (dp_addr == RSQ_OFS_XTAL);
  wire         wr_xtal2  = dp_wr_r && (dp_addr == RSQ_OFS_XTAL2);
  wire         wr_wdog   = dp_wr_r && (dp_addr == RSQ_OFS_WDOG);
  wire [7:0]   irq_en_w  = hwdata[7:0] & 8'h92;

  // Reset source enables.
  wire         xtal_en   = xtal_r[RSQ_BIT_XTAL_EN] && !full_stop_mode;
  wire         mon_en    = xtal_en && xtal2_r[RSQ_BIT_MON_EN];
  wire         mon_fault = mon_en && (osc_lost || osc_below_threshold);
  wire         wd_en     = |wdog_r[2:0];
  wire         wd_fault  = wd_en && watchdog_timeout;
  wire         src_event = mon_rst_r || wd_rst_r;
  wire [7:0]   status    = {5'h00, wd_en, mon_en, sys_reset};

  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (ap_addr)
      RSQ_OFS_IRQ_EN: rd_mux = {24'h000000, irq_en_r};
      RSQ_OFS_TEST:   rd_mux = {24'h000000, test_r};
      RSQ_OFS_XTAL:   rd_mux = {24'h000000, xtal_r};
      RSQ_OFS_XTAL2:  rd_mux = {24'h000000, xtal2_r};
      RSQ_OFS_WDOG:   rd_mux = {24'h000000, wdog_r};
      RSQ_OFS_STATUS: rd_mux = {24'h000000, status};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata_r  <= 32'h00000000;
    end
    else
    begin
      dp_wr_r   <= ap_valid && hwrite;
      dp_addr_r <= ap_addr;
      if (ap_read)
        hrdata_r <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_en_r <= RSQ_IRQ_EN_RST;
      test_r   <= RSQ_TEST_RST;
      xtal_r   <= RSQ_XTAL_RST;
      xtal2_r  <= RSQ_XTAL2_RST;
      wdog_r   <= RSQ_WDOG_RST;
    end
    else
    begin
      if (wr_irq)
        irq_en_r <= irq_en_w;
      if (wr_test)
        test_r <= hwdata[7:0];
      if (wr_xtal)
        xtal_r <= hwdata[7:0];
      if (wr_xtal2)
        xtal2_r <= hwdata[7:0];
      if (wr_wdog)
        wdog_r <= hwdata[7:0];
    end
  end

  // Fault latches register the source so the sequencer sees a clean event.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mon_rst_r <= 1'b0;
      wd_rst_r  <= 1'b0;
    end
    else
    begin
      mon_rst_r <= mon_fault && !sys_reset;
      wd_rst_r  <= wd_fault && !sys_reset;
    end
  end

  rsq_seq u_seq (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .src_event (src_event),
    .pin_in    (reset_pin_in),
    .pin_out   (reset_pin_out),
    .pin_oe    (reset_pin_oe),
    .sys_reset (sys_reset),
    .busy      ()
  );

  assign vco_reset_select  = sys_reset;
  assign crystal_run       = xtal_en;
  assign watchdog_armed    = wd_en;
  assign tick_irq          = tick_flag && irq_en_r[RSQ_BIT_TICK_EN];
  assign pll_locked_irq    = pll_locked_change_flag && irq_en_r[RSQ_BIT_LOCK_EN];
  assign clock_corrupt_irq = clock_corrupt_flag && irq_en_r[RSQ_BIT_CORR_EN];
  assign hrdata            = hrdata_r;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;

  a_tick_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    tick_irq == (tick_flag && irq_en_r[RSQ_BIT_TICK_EN])) else $error("tick gate wrong");
  a_lock_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    !irq_en_r[RSQ_BIT_LOCK_EN] |-> !pll_locked_irq) else $error("lock irq leaked");
  a_corr_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    (clock_corrupt_flag && irq_en_r[RSQ_BIT_CORR_EN]) |-> clock_corrupt_irq)
    else $error("corrupt irq");
  a_irq_write: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_irq |=> irq_en_r == $past(irq_en_w)) else $error("enable write lost");
  a_test_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    !special_mode |=> $stable(test_r)) else $error("test reg written");
  a_mon_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    (mon_fault && !sys_reset) |=> ##1 sys_reset) else $error("no monitor reset");
  a_stop_mon: assert property (@(posedge core_clk) disable iff (!resetn)
    full_stop_mode |-> !mon_en) else $error("monitor on in stop");
  a_wd_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    (wd_fault && !sys_reset) |=> ##1 reset_pin_oe) else $error("no watchdog reset");
  a_vco_sel: assert property (@(posedge core_clk) disable iff (!resetn)
    sys_reset |-> vco_reset_select) else $error("vco select off");
  c_mon: cover property (@(posedge core_clk) disable iff (!resetn) mon_rst_r);
  c_wd: cover property (@(posedge core_clk) disable iff (!resetn) wd_rst_r);
  c_tick: cover property (@(posedge core_clk) disable iff (!resetn) tick_irq);
endmodule : rsq_top
`default_nettype wire

/* verif/rsq_pin_model.sv */
// Board side of the block: reset line with a pull-up, and the crystal.
// Assumes the bench requests faults synchronously to core_clk.
`timescale 1ns/1ps
`default_nettype none
module rsq_pin_model (
  input  wire logic       pin_oe,
  input  wire logic       ext_low,
  input  wire logic [1:0] fail_kind,
  output logic            pin_level,
  output logic            osc_lost,
  output logic            osc_below
);
  assign pin_level = (pin_oe || ext_low) ? 1'b0 : 1'b1;
  assign osc_lost  = fail_kind == 2'h1;
  assign osc_below = fail_kind == 2'h2;
endmodule : rsq_pin_model
`default_nettype wire

/* verif/rsq_top_test.sv */
// Bench for rsq_top: register bus, interrupt gating and reset sequencing.
// Assumes rsq_pin_model stands for the reset line and the crystal.
`timescale 1ns/1ps
`default_nettype none
module rsq_top_test;
  import rsq_pkg::*;
  logic        core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp, ext_low;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0]  hsize;
  logic [1:0]  htrans, fail_kind;
  logic        tick_flag, pll_locked_change_flag, clock_corrupt_flag, tick_irq;
  logic        pll_locked_irq, clock_corrupt_irq, special_mode, full_stop_mode;
  logic        osc_lost, osc_below_threshold, watchdog_timeout, watchdog_armed;
  logic        reset_pin_in, reset_pin_out, reset_pin_oe, sys_reset, vco_reset_select;
  logic        crystal_run;
  int          n_errors = 0;
  int          n_compared = 0;
  assign hready = hreadyout;
  rsq_top u_rsq_top (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tick_flag, .pll_locked_change_flag,
    .clock_corrupt_flag, .special_mode, .full_stop_mode, .osc_lost, .osc_below_threshold,
    .watchdog_timeout, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .sys_reset,
    .vco_reset_select, .crystal_run, .tick_irq, .pll_locked_irq, .clock_corrupt_irq,
    .watchdog_armed);
  rsq_pin_model u_rsq_pin_model (.pin_oe(reset_pin_oe), .ext_low, .fail_kind,
    .pin_level(reset_pin_in), .osc_lost, .osc_below(osc_below_threshold));
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (hreadyout === 1'b1)
        return;
    end
    n_errors++;
    stop_test();
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [31:0] e);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= RSQ_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    chk(hresp, 1'b0);
    if (!wr)
      chk(hrdata, e);
  endtask : bus
  task automatic seq_check(input int ep, input int es);
    int p = 0;
    int s = 0;
    repeat (1200)
    begin
      @(posedge core_clk);
      p += int'(reset_pin_oe === 1'b1 && reset_pin_out === 1'b0);
      s += int'(sys_reset === 1'b1 && vco_reset_select === 1'b1);
    end
    chk(p, ep);
    chk(s, es);
  endtask : seq_check
  task automatic t_irq;
    logic [7:0] en [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h6D, 8'h10, 8'h82, 8'h82};
    logic [2:0] fl [7] = '{3'h4, 3'h2, 3'h1, 3'h7, 3'h7, 3'h7, 3'h0};
    for (int k = 0; k < 7; k++)
    begin
      bus(1'b1, RSQ_OFS_IRQ_EN, en[k], '0);
      {tick_flag, pll_locked_change_flag, clock_corrupt_flag} <= fl[k];
      repeat (2) @(posedge core_clk);
      chk({tick_irq, pll_locked_irq, clock_corrupt_irq},
          fl[k] & {en[k][7], en[k][4], en[k][1]});
      bus(1'b0, RSQ_OFS_IRQ_EN, 8'h00, en[k] & 8'h92);
    end
  endtask : t_irq
  task automatic t_test_reg;
    bus(1'b1, RSQ_OFS_TEST, 8'h5A, '0);
    bus(1'b0, RSQ_OFS_TEST, 8'h00, {24'h0, RSQ_TEST_RST});
    special_mode <= 1'b1;
    bus(1'b1, RSQ_OFS_TEST, 8'hA5, '0);
    special_mode <= 1'b0;
    bus(1'b0, RSQ_OFS_TEST, 8'h00, 32'hA5);
    bus(1'b0, 12'h040, 8'h00, 32'h0);
  endtask : t_test_reg
  task automatic t_sources;
    // Fields: crystal, monitor, full stop, fault kind, watchdog rate, reset due.
    logic [8:0] c [9] = '{9'h010, 9'h110, 9'h090, 9'h1D0, 9'h191, 9'h1A1, 9'h000,
                          9'h00F, 9'h003};
    for (int k = 0; k < 9; k++)
    begin
      bus(1'b1, RSQ_OFS_XTAL, {c[k][8], 7'h0}, '0);
      bus(1'b1, RSQ_OFS_XTAL2, {7'h0, c[k][7]}, '0);
      bus(1'b1, RSQ_OFS_WDOG, {5'h0, c[k][3:1]}, '0);
      full_stop_mode <= c[k][6];
      repeat (2) @(posedge core_clk);
      chk(crystal_run, c[k][8] & ~c[k][6]);
      chk(watchdog_armed, |c[k][3:1]);
      fail_kind <= c[k][5:4];
      watchdog_timeout <= c[k][5:4] == 2'h0;
      @(posedge core_clk);
      fail_kind <= 2'h0;
      watchdog_timeout <= 1'b0;
      seq_check(c[k][0] ? 512 : 0, c[k][0] ? 768 : 0);
    end
    full_stop_mode <= 1'b0;
  endtask : t_sources
  task automatic t_ext;
    ext_low <= 1'b1;
    repeat (1000) @(posedge core_clk);
    chk(sys_reset, 1'b1);
    ext_low <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(sys_reset, 1'b0);
  endtask : t_ext
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    {resetn, hsel, hwrite, ext_low, tick_flag, pll_locked_change_flag} = '0;
    {clock_corrupt_flag, special_mode, full_stop_mode, watchdog_timeout} = '0;
    {haddr, hwdata, htrans, fail_kind} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    seq_check(512, 768);
    t_irq();
    t_test_reg();
    t_sources();
    t_ext();
    stop_test();
  end
endmodule : rsq_top_test
`default_nettype wire
